// [core/lsr_host.sv]
/*
 Host end: APB slave register file that steers a serial bus master which
 writes, reads or restarts the sensor. Assumes the sensor never stretches the clock.
*/
`timescale 1ns/1ps
module lsr_host
   import lsr_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Serial link
   lsr_i2c_if.host i2c
);
   typedef enum {M_IDLE, M_START, M_BYTE, M_STOP} lsr_mst_t;

   lsr_mst_t mst_reg;
   logic [2:0] step_reg;
   logic [1:0] q_reg;
   logic [7:0] qdiv_reg;
   logic qtick;
   logic [8:0] tx_reg;
   logic [8:0] rx_reg;
   logic [3:0] bitn_reg;
   logic scl_l_reg;
   logic sda_l_reg;
   logic [1:0] sda_sync_reg;
   logic busy_reg;
   logic nack_reg;
   logic [7:0] rdata_reg;
   logic [7:0] wdat_reg;
   logic [7:0] idx_reg;
   logic rd_reg;
   logic idxonly_reg;
   logic asel_reg;
   logic mapped;
   logic go;
   logic [8:0] rx_new;

   assign mapped = paddr == REG_CTRL || paddr == REG_STAT || paddr == REG_RDATA;
   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;
   // Writes while busy are dropped; software polls the busy bit first
   assign go = psel && penable && pwrite && paddr == REG_CTRL && !busy_reg;

   // Read data set up in the setup cycle, stable through the access phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
      end else if (psel && !penable) begin
         unique case (paddr)
            REG_CTRL: prdata <= {13'h0000, asel_reg, idxonly_reg, rd_reg, idx_reg, wdat_reg};
            REG_STAT: prdata <= {30'h00000000, nack_reg, busy_reg};
            REG_RDATA: prdata <= {24'h000000, rdata_reg};
            default: prdata <= 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sda_sync_reg <= 2'h3;
      end else begin
         sda_sync_reg <= {sda_sync_reg[0], i2c.sda};
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         qdiv_reg <= 8'h00;
      end else if (qtick || mst_reg == M_IDLE) begin
         qdiv_reg <= 8'h00;
      end else begin
         qdiv_reg <= qdiv_reg + 8'h01;
      end
   end
   assign qtick = qdiv_reg == 8'(QTR_CYC - 1);
   assign rx_new = {rx_reg[7:0], sda_sync_reg[1]};

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mst_reg <= M_IDLE;
         step_reg <= 3'h0;
         q_reg <= 2'h0;
         tx_reg <= 9'h1ff;
         rx_reg <= 9'h000;
         bitn_reg <= 4'h0;
         scl_l_reg <= 1'b1;
         sda_l_reg <= 1'b1;
         busy_reg <= 1'b0;
         nack_reg <= 1'b0;
         rdata_reg <= 8'h00;
         wdat_reg <= 8'h00;
         idx_reg <= 8'h00;
         rd_reg <= 1'b0;
         idxonly_reg <= 1'b0;
         asel_reg <= 1'b0;
      end else if (go) begin
         wdat_reg <= pwdata[CTRL_DATA_LSB +: 8];
         idx_reg <= pwdata[CTRL_IDX_LSB +: 8];
         rd_reg <= pwdata[CTRL_READ];
         idxonly_reg <= pwdata[CTRL_IDXONLY];
         asel_reg <= pwdata[CTRL_ASEL];
         busy_reg <= 1'b1;
         nack_reg <= 1'b0;
         mst_reg <= M_START;
         step_reg <= 3'h1;
         q_reg <= 2'h0;
      end else if (qtick) begin
         q_reg <= q_reg + 2'h1;
         unique case (mst_reg)
            M_START: begin
               unique case (q_reg)
                  // Clock left as is, so a start from idle has no clock glitch
                  2'h0: sda_l_reg <= 1'b1;
                  2'h1: scl_l_reg <= 1'b1;
                  2'h2: sda_l_reg <= 1'b0;
                  2'h3: begin
                     scl_l_reg <= 1'b0;
                     tx_reg <= {DEV_ADDR_BASE[6:1], asel_reg, step_reg == 3'h4, 1'b1};
                     bitn_reg <= 4'h0;
                     mst_reg <= M_BYTE;
                  end
               endcase
            end
            M_BYTE: begin
               unique case (q_reg)
                  2'h0: sda_l_reg <= tx_reg[8];
                  2'h1: scl_l_reg <= 1'b1;
                  2'h2: rx_reg <= rx_new;
                  2'h3: begin
                     scl_l_reg <= 1'b0;
                     tx_reg <= {tx_reg[7:0], 1'b1};
                     bitn_reg <= bitn_reg + 4'h1;
                     if (bitn_reg == 4'h8) begin
                        mst_reg <= M_STOP;
                        if (rx_reg[0] && step_reg != 3'h5) begin
                           nack_reg <= 1'b1;
                        end else begin
                           unique case (step_reg)
                              3'h1: begin
                                 step_reg <= 3'h2;
                                 tx_reg <= {idx_reg, 1'b1};
                                 bitn_reg <= 4'h0;
                                 mst_reg <= M_BYTE;
                              end
                              3'h2: begin
                                 if (idxonly_reg) begin
                                    mst_reg <= M_STOP;
                                 end else if (rd_reg) begin
                                    step_reg <= 3'h4;
                                    mst_reg <= M_START;
                                 end else begin
                                    step_reg <= 3'h3;
                                    tx_reg <= {wdat_reg, 1'b1};
                                    bitn_reg <= 4'h0;
                                    mst_reg <= M_BYTE;
                                 end
                              end
                              3'h4: begin
                                 step_reg <= 3'h5;
                                 tx_reg <= 9'h1ff;
                                 bitn_reg <= 4'h0;
                                 mst_reg <= M_BYTE;
                              end
                              3'h5: rdata_reg <= rx_reg[8:1];
                              default: mst_reg <= M_STOP;
                           endcase
                        end
                     end
                  end
               endcase
            end
            M_STOP: begin
               unique case (q_reg)
                  2'h0: sda_l_reg <= 1'b0;
                  2'h1: scl_l_reg <= 1'b1;
                  2'h2: sda_l_reg <= 1'b1;
                  2'h3: begin
                     mst_reg <= M_IDLE;
                     busy_reg <= 1'b0;
                     step_reg <= 3'h0;
                  end
               endcase
            end
            M_IDLE: q_reg <= 2'h0;
         endcase
      end
   end

   assign i2c.m_scl_o = 1'b0;
   assign i2c.m_scl_oe = !scl_l_reg;
   assign i2c.m_sda_o = 1'b0;
   assign i2c.m_sda_oe = !sda_l_reg;
endmodule

// [core/lsr_i2c_if.sv]
/*
 Two-wire link between the host controller and the sensor.
 Both lines are open drain with pull-ups; a party pulls low when its enable is high and its output is low.
*/
`timescale 1ns/1ps
interface lsr_i2c_if;
   logic m_scl_o;
   logic m_scl_oe;
   logic m_sda_o;
   logic m_sda_oe;
   logic s_sda_o;
   logic s_sda_oe;
   logic scl;
   logic sda;

   // Wired-AND of the pulled-up lines
   assign scl = !(m_scl_oe && !m_scl_o);
   assign sda = !((m_sda_oe && !m_sda_o) || (s_sda_oe && !s_sda_o));

   modport host (output m_scl_o, output m_scl_oe, output m_sda_o, output m_sda_oe, input scl, input sda);
   modport dev (output s_sda_o, output s_sda_oe, input scl, input sda);
endinterface

// [core/lsr_pkg.sv]
/*
 Shared constants of the light sensor readout: register indices, command
 field positions, timing decode, oscillator and link timing, host register map.
 Assumes a 10 MHz system clock on both ends of the serial link.
*/
package lsr_pkg;
   // Sensor register indices
   localparam logic [7:0] IDX_CMD = 8'h00;
   localparam logic [7:0] IDX_RES_LO = 8'h01;
   localparam logic [7:0] IDX_RES_HI = 8'h02;
   localparam int B_RESTART = 7;
   // Command field positions
   localparam int B_EN = 7;
   localparam int B_MODE = 6;
   localparam int B_LIGHT = 5;
   localparam int B_TMSB = 4;
   localparam int B_RESHI = 3;
   localparam int B_RESLO = 2;
   localparam int B_FSHI = 1;
   localparam int B_FSLO = 0;
   // Reset values
   localparam logic [7:0] CMD_RESET = 8'h00;
   localparam logic [15:0] RESULT_RESET = 16'h0000;
   // Slave address, low bit taken from address_select_pin
   localparam logic [6:0] DEV_ADDR_BASE = 7'h44;
   // Timing and resolution codes
   localparam logic [2:0] TR_INT16 = 3'h0;
   localparam logic [2:0] TR_INT12 = 3'h1;
   localparam logic [2:0] TR_INT8 = 3'h2;
   localparam logic [2:0] TR_INT4 = 3'h3;
   localparam logic [2:0] TR_EXT_ADC = 3'h4;
   localparam logic [2:0] TR_EXT_TMR = 3'h5;
   // Oscillator cycles per internal conversion
   localparam int CYC_16BIT = 65536;
   localparam int CYC_12BIT = 4096;
   localparam int CYC_8BIT = 256;
   localparam int CYC_4BIT = 16;
   // Oscillator and clock rates
   localparam int CLK_FREQ_KHZ = 10000;
   localparam int OSC_FREQ_KHZ = 725;
   localparam int OSC_DIV = CLK_FREQ_KHZ / OSC_FREQ_KHZ;
   // Serial link timing
   localparam int CLK_PERIOD_NS = 100;
   localparam int LINK_PERIOD_NS = 800;
   localparam int QTR_CYC = LINK_PERIOD_NS / (4 * CLK_PERIOD_NS);
   // Host register map
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STAT = 8'h04;
   localparam logic [7:0] REG_RDATA = 8'h08;
   localparam int CTRL_DATA_LSB = 0;
   localparam int CTRL_IDX_LSB = 8;
   localparam int CTRL_READ = 16;
   localparam int CTRL_IDXONLY = 17;
   localparam int CTRL_ASEL = 18;
   localparam int STAT_BUSY = 0;
   localparam int STAT_NACK = 1;
endpackage

// [core/lsr_sensor.sv]
/*
 Sensor end: serial slave, command and result registers, measurement sequencer
 and a digital stand-in for the integrating converter.
 Assumes scl and sda arrive asynchronously and that the light levels are quasi-static inputs.
*/
// Our own choice: register access over APB.
// Overview of operation
// - Reset: powered down, registers zero
// - One-shot: one conversion, then power down
// - Writing enable low stops measuring
// - Bit 7 enables device
// - Bit 6 picks one-shot or continuous
// - Bit 5 picks ambient or infrared
// - Bits 4:2 decode timing and resolution
// - Internal timing cycles: 65536/4096/256/16
// - External timing integrates between restart writes
// - Index bit 7 restarts integration
// - Timer output holds cycles between restarts
// - Master selects converter output in external timing
// - Bits 1:0 pick full-scale range
// - Command register readable, holds value
// - Result low at 01, high 02
// - Results refresh after every conversion
// - Host scales reading by range over 2^n
// - Slave address set by select pin
// - Master keeps external interval below overflow
`timescale 1ns/1ps
module lsr_sensor
   import lsr_pkg::*;
#(
   parameter int OSC_DIVIDE = OSC_DIV,
   parameter int CYCLES_16BIT = CYC_16BIT
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Serial link
   lsr_i2c_if.dev i2c,
   // Strap and light inputs
   input wire logic address_select_pin,
   input wire logic [7:0] ambient_level,
   input wire logic [7:0] infrared_level,
   // Observation
   output logic powered_up
);
   typedef enum {S_OFF, S_RUN} lsr_meas_t;
   typedef enum {I_IDLE, I_ADDR, I_IDX, I_WR, I_RD} lsr_link_t;

   logic [7:0] measurement_control_reg;
   logic [15:0] result_reg;
   lsr_meas_t meas_reg;
   lsr_link_t link_reg;
   logic [2:0] scl_sync_reg;
   logic [2:0] sda_sync_reg;
   logic [3:0] bitcnt_reg;
   logic [7:0] shift_reg;
   logic [7:0] rd_shift_reg;
   logic [7:0] index_reg;
   logic sda_drv_reg;
   logic rw_reg;
   logic master_ack_reg;
   logic cmd_wr, restart;
   logic [7:0] rd_data;
   logic scl_rise, scl_fall, start_cond, stop_cond;
   logic [1:0] asel_sync_reg;
   logic [6:0] my_addr;
   logic [15:0] osc_div_reg;
   logic osc_tick;
   logic [16:0] ticks_reg;
   logic [23:0] acc_reg;
   logic [16:0] cycles_limit;
   logic [7:0] level;
   logic [15:0] adc_value;
   logic ext_live_reg;
   logic [2:0] tsel;

   // Only the second and third stages feed edge logic
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         scl_sync_reg <= 3'h7;
         sda_sync_reg <= 3'h7;
         asel_sync_reg <= 2'h0;
      end else begin
         scl_sync_reg <= {scl_sync_reg[1:0], i2c.scl};
         sda_sync_reg <= {sda_sync_reg[1:0], i2c.sda};
         asel_sync_reg <= {asel_sync_reg[0], address_select_pin};
      end
   end

   assign scl_rise = scl_sync_reg[1] && !scl_sync_reg[2];
   assign scl_fall = !scl_sync_reg[1] && scl_sync_reg[2];
   assign start_cond = scl_sync_reg[1] && scl_sync_reg[2] && sda_sync_reg[2] && !sda_sync_reg[1];
   assign stop_cond = scl_sync_reg[1] && scl_sync_reg[2] && !sda_sync_reg[2] && sda_sync_reg[1];
   assign my_addr = {DEV_ADDR_BASE[6:1], asel_sync_reg[1]};

   always_comb begin
      unique case (index_reg)
         IDX_CMD: rd_data = measurement_control_reg;
         IDX_RES_LO: rd_data = result_reg[7:0];
         IDX_RES_HI: rd_data = result_reg[15:8];
         default: rd_data = 8'h00;
      endcase
   end

   // Bytes are acked on the fall after the eighth bit and released one bit later
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         link_reg <= I_IDLE;
         bitcnt_reg <= 4'h0;
         shift_reg <= 8'h00;
         rd_shift_reg <= 8'h00;
         index_reg <= IDX_CMD;
         sda_drv_reg <= 1'b0;
         rw_reg <= 1'b0;
         master_ack_reg <= 1'b0;
      end else if (start_cond) begin
         link_reg <= I_ADDR;
         bitcnt_reg <= 4'h0;
         sda_drv_reg <= 1'b0;
      end else if (stop_cond) begin
         link_reg <= I_IDLE;
         sda_drv_reg <= 1'b0;
      end else if (link_reg != I_IDLE) begin
         if (scl_rise) begin
            bitcnt_reg <= bitcnt_reg + 4'h1;
            if (bitcnt_reg < 4'h8) begin
               shift_reg <= {shift_reg[6:0], sda_sync_reg[1]};
            end else begin
               master_ack_reg <= !sda_sync_reg[1];
            end
         end else if (scl_fall) begin
            if (bitcnt_reg == 4'h8) begin
               unique case (link_reg)
                  I_ADDR: begin
                     if (shift_reg[7:1] == my_addr) begin
                        sda_drv_reg <= 1'b1;
                        rw_reg <= shift_reg[0];
                     end else begin
                        link_reg <= I_IDLE;
                     end
                  end
                  I_IDX: begin
                     index_reg <= shift_reg;
                     sda_drv_reg <= 1'b1;
                  end
                  I_WR: sda_drv_reg <= 1'b1;
                  I_RD: sda_drv_reg <= 1'b0;
                  default: sda_drv_reg <= 1'b0;
               endcase
            end else if (bitcnt_reg == 4'h9) begin
               bitcnt_reg <= 4'h0;
               sda_drv_reg <= 1'b0;
               unique case (link_reg)
                  I_ADDR: begin
                     if (rw_reg) begin
                        link_reg <= I_RD;
                        rd_shift_reg <= rd_data;
                        sda_drv_reg <= !rd_data[7];
                     end else begin
                        link_reg <= I_IDX;
                     end
                  end
                  I_IDX: link_reg <= I_WR;
                  I_WR: link_reg <= I_WR;
                  I_RD: begin
                     if (master_ack_reg) begin
                        index_reg <= index_reg + 8'h01;
                        link_reg <= I_RD;
                     end else begin
                        link_reg <= I_IDLE;
                     end
                  end
                  default: link_reg <= I_IDLE;
               endcase
            end else if (link_reg == I_RD && bitcnt_reg != 4'h0) begin
               rd_shift_reg <= {rd_shift_reg[6:0], 1'b0};
               sda_drv_reg <= !rd_shift_reg[6];
            end
         end
      end
   end

   assign cmd_wr = scl_fall && bitcnt_reg == 4'h8 && link_reg == I_WR && index_reg == IDX_CMD && !start_cond
      && !stop_cond;
   assign restart = scl_fall && bitcnt_reg == 4'h8 && link_reg == I_IDX && shift_reg[B_RESTART]
      && !start_cond && !stop_cond;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         measurement_control_reg <= CMD_RESET;
      end else if (cmd_wr) begin
         measurement_control_reg <= shift_reg;
      end
   end

   // Internal oscillator stand-in
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         osc_div_reg <= 16'h0000;
      end else if (osc_tick) begin
         osc_div_reg <= 16'h0000;
      end else begin
         osc_div_reg <= osc_div_reg + 16'h0001;
      end
   end
   assign osc_tick = osc_div_reg == 16'(OSC_DIVIDE - 1);

   assign tsel = measurement_control_reg[B_TMSB:B_RESLO];
   always_comb begin
      unique case (tsel[1:0])
         2'h0: cycles_limit = 17'(CYCLES_16BIT);
         2'h1: cycles_limit = 17'(CYC_12BIT);
         2'h2: cycles_limit = 17'(CYC_8BIT);
         2'h3: cycles_limit = 17'(CYC_4BIT);
      endcase
   end
   // Wider ranges attenuate the input by two bits per step
   assign level = (measurement_control_reg[B_LIGHT] ? infrared_level : ambient_level)
      >> {measurement_control_reg[B_FSHI:B_FSLO], 1'b0};
   assign adc_value = (acc_reg[23:8] == 16'hffff) ? 16'hffff : acc_reg[23:8];

   // Sequencer; a command write always wins over an ongoing conversion
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meas_reg <= S_OFF;
         ticks_reg <= 17'h00000;
         acc_reg <= 24'h000000;
         result_reg <= RESULT_RESET;
         ext_live_reg <= 1'b0;
      end else if (cmd_wr) begin
         meas_reg <= shift_reg[B_EN] ? S_RUN : S_OFF;
         ticks_reg <= 17'h00000;
         acc_reg <= 24'h000000;
         ext_live_reg <= 1'b0;
      end else if (meas_reg == S_RUN) begin
         if (!tsel[2]) begin
            if (osc_tick) begin
               if (ticks_reg == cycles_limit - 17'h00001) begin
                  result_reg <= (acc_reg + 24'(level)) >> 8 > 24'h00ffff ? 16'hffff
                     : 16'((acc_reg + 24'(level)) >> 8);
                  ticks_reg <= 17'h00000;
                  acc_reg <= 24'h000000;
                  if (!measurement_control_reg[B_MODE]) begin
                     meas_reg <= S_OFF;
                  end
               end else begin
                  ticks_reg <= ticks_reg + 17'h00001;
                  acc_reg <= acc_reg + 24'(level);
               end
            end
         end else if (tsel == TR_EXT_ADC || tsel == TR_EXT_TMR) begin
            if (restart) begin
               ticks_reg <= 17'h00000;
               acc_reg <= 24'h000000;
               ext_live_reg <= 1'b1;
               if (ext_live_reg) begin
                  result_reg <= (tsel == TR_EXT_TMR) ? ticks_reg[15:0] : adc_value;
                  if (!measurement_control_reg[B_MODE]) begin
                     meas_reg <= S_OFF;
                  end
               end
            end else if (osc_tick && ext_live_reg) begin
               ticks_reg <= ticks_reg + 17'h00001;
               acc_reg <= acc_reg + 24'(level);
            end
         end
      end
   end

   assign i2c.s_sda_o = 1'b0;
   assign i2c.s_sda_oe = sda_drv_reg;
   assign powered_up = meas_reg == S_RUN;
endmodule

// [dv/light_sensor_command_and_data_regs_tb.sv]
/*
 Bench: host and sensor face each other over the link; APB reads checked from a queue.
 Assumes shortened oscillator counts; the master waits on pready.
*/
`timescale 1ns/1ps
module light_sensor_command_and_data_regs_tb;
   import lsr_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, chk_rd, address_select_pin, powered_up, pready, pslverr, asel;
   logic [7:0] paddr, ambient_level, infrared_level, lv, amb, ir, cmd;
   logic [31:0] pwdata, prdata, rd, e16, tick;
   logic [15:0] tmr;
   logic [32:0] exp_q[$];
   int miscompares = 0, checked = 0, seed = 32'h2188, cyc = 0, i, n, t0;
   lsr_i2c_if i2c_bus();
   lsr_host i_lsr_host (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .i2c(i2c_bus));
   // Short counts keep the run small
   lsr_sensor #(.OSC_DIVIDE(1), .CYCLES_16BIT(64)) i_lsr_sensor (.pclk(pclk), .presetn(presetn), .i2c(i2c_bus),
      .address_select_pin(address_select_pin), .ambient_level(ambient_level), .infrared_level(infrared_level),
      .powered_up(powered_up));
   lsr_properties i_lsr_properties (.pclk(pclk), .presetn(presetn), .m_scl_o(i2c_bus.m_scl_o),
      .m_scl_oe(i2c_bus.m_scl_oe), .m_sda_o(i2c_bus.m_sda_o), .m_sda_oe(i2c_bus.m_sda_oe),
      .s_sda_o(i2c_bus.s_sda_o), .s_sda_oe(i2c_bus.s_sda_oe), .scl(i2c_bus.scl), .sda(i2c_bus.sda));
   task automatic check(input logic [32:0] got, input logic [32:0] exp);
      checked++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic stop_test();
      $display("Comparisons %0d, mismatches %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic chk,
      input logic [32:0] e);
      if (chk) exp_q.push_back(e);
      psel <= 1'b1;
      paddr <= a;
      pwrite <= wr;
      pwdata <= d;
      chk_rd <= chk;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   // One link transfer, then the status word it leaves
   task automatic sen(input logic [18:0] ctrl, input logic [32:0] e);
      apb(1'b1, REG_CTRL, {13'h0, asel, ctrl[17:0]}, 1'b0, 33'h0);
      rd = 32'h1;
      while (rd[STAT_BUSY] !== 1'b0) apb(1'b0, REG_STAT, 32'h0, 1'b0, 33'h0);
      apb(1'b0, REG_STAT, 32'h0, 1'b1, e);
   endtask
   task automatic sen_rd(input logic [7:0] idx, input logic chk, input logic [7:0] e);
      sen({3'b001, idx, 8'h00}, 33'h0);
      apb(1'b0, REG_RDATA, 32'h0, chk, {25'h0, e});
   endtask
   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (psel && penable && pready && !pwrite && chk_rd) check({pslverr, prdata}, exp_q.pop_front());
   end
   initial begin
      {psel, penable, pwrite, chk_rd, address_select_pin, asel, presetn} = 7'h00;
      {paddr, ambient_level, infrared_level, pwdata} = 56'h0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, REG_STAT, 32'h0, 1'b1, 33'h0);
      apb(1'b0, 8'h0c, 32'h0, 1'b1, {1'b1, 32'h0});
      for (i = 0; i < 3; i++) sen_rd(i, 1'b1, 8'h00);
      asel = 1'b1;
      sen({3'b000, IDX_CMD, 8'h00}, 33'h2);
      address_select_pin <= 1'b1;
      cmd = $random(seed) & 32'h7f;
      sen({3'b000, IDX_CMD, cmd}, 33'h0);
      sen_rd(IDX_CMD, 1'b1, cmd);
      check({32'h0, powered_up}, 33'h0);
      // One-shot over every internal code, light path and a random range
      for (i = 0; i < 4; i++) begin
         amb = $random(seed) | 32'h80;
         ir = $random(seed) | 32'h80;
         ambient_level <= amb;
         infrared_level <= ir;
         cmd = {2'b10, i[0], 1'b0, i[1:0], 2'($random(seed))};
         lv = i[0] ? ir : amb;
         tick = (i == 0) ? 64 : (1 << (16 - 4 * i));
         e16 = (tick * (lv >> (2 * cmd[1:0]))) >> 8;
         sen({3'b000, IDX_CMD, cmd}, 33'h0);
         for (n = 0; n < 9000 && powered_up !== 1'b0; n++) @(posedge pclk);
         check({32'h0, powered_up}, 33'h0);
         sen_rd(IDX_RES_LO, 1'b1, e16[7:0]);
         sen_rd(IDX_RES_HI, 1'b1, e16[15:8]);
      end
      sen_rd(IDX_RES_LO, 1'b1, e16[7:0]);
      // Continuous: the 8-bit result follows a changed level
      sen({3'b000, IDX_CMD, 8'hc8}, 33'h0);
      lv = $random(seed);
      ambient_level <= lv;
      repeat (600) @(posedge pclk);
      check({32'h0, powered_up}, 33'h1);
      sen_rd(IDX_RES_LO, 1'b1, lv);
      sen({3'b000, IDX_CMD, 8'h48}, 33'h0);
      check({32'h0, powered_up}, 33'h0);
      // External timing, timer then converter output; both restarts take equal link time
      for (n = 0; n < 2; n++) begin
         sen({3'b000, IDX_CMD, n[0] ? 8'hd0 : 8'hd4}, 33'h0);
         sen({3'b010, 8'h80, 8'h00}, 33'h0);
         t0 = cyc;
         repeat (200 + ($random(seed) & 32'h1ff)) @(posedge pclk);
         sen({3'b010, 8'h80, 8'h00}, 33'h0);
         t0 = cyc - t0;
         e16 = n[0] ? (t0 * lv) >> 8 : t0;
         sen_rd(IDX_RES_LO, 1'b0, 8'h00);
         tmr[7:0] = rd[7:0];
         sen_rd(IDX_RES_HI, 1'b0, 8'h00);
         tmr[15:8] = rd[7:0];
         check({32'h0, tmr + 16'd8 >= e16[15:0] && tmr <= e16[15:0] + 16'd8}, 33'h1);
      end
      stop_test();
   end
   initial begin
      repeat (60000) @(posedge pclk);
      miscompares++;
      stop_test();
   end
endmodule

// [dv/lsr_properties.sv]
/*
 Link checker: timing and ownership of the two shared lines.
 Assumes the link signals of the bench, all in the pclk domain.
*/
`timescale 1ns/1ps
module lsr_properties (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Host drive
   input wire logic m_scl_o,
   input wire logic m_scl_oe,
   input wire logic m_sda_o,
   input wire logic m_sda_oe,
   // Sensor drive
   input wire logic s_sda_o,
   input wire logic s_sda_oe,
   // Resolved lines
   input wire logic scl,
   input wire logic sda
);
   logic [4:0] hi_cnt;
   // Saturates, so a long idle never wraps
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hi_cnt <= 5'h00;
      end else if (!scl) begin
         hi_cnt <= 5'h00;
      end else if (hi_cnt != 5'h1f) begin
         hi_cnt <= hi_cnt + 5'h01;
      end
   end
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   a_idle_after_reset: assert property ($rose(presetn) |-> scl && sda && !s_sda_oe)
      else $error("link busy after reset");
   a_scl_high_hold: assert property ($rose(scl) |-> scl [*3])
      else $error("clock high too short");
   a_scl_low_hold: assert property ($fell(scl) |-> !scl [*3])
      else $error("clock low too short");
   a_scl_low_bound: assert property ($fell(scl) |-> ##[1:12] scl)
      else $error("clock stuck low");
   a_slave_edge_low: assert property ($changed(s_sda_oe) |-> !scl)
      else $error("sensor moved data while clock high");
   // Ack hand-over may overlap for a cycle while the clock is low; both pull low then
   a_one_sda_driver: assert property (scl |-> !(s_sda_oe && m_sda_oe))
      else $error("both ends pull data while clock high");
   a_start_by_host: assert property (scl && $changed(sda) |-> $changed(m_sda_oe))
      else $error("data moved under high clock");
   a_slave_quiet_idle: assert property (hi_cnt > 5'h10 |-> !s_sda_oe)
      else $error("sensor pulls idle bus");
   c_slave_ack: cover property ($rose(s_sda_oe));
   c_start: cover property (scl && $fell(sda));
   c_stop: cover property (scl && $rose(sda));
endmodule
